// ===== core/tape_continue_consts.svh
// Constants for the tape continue control block.
`ifndef TAPE_CONTINUE_CONSTS_SVH
`define TAPE_CONTINUE_CONSTS_SVH
`define CC_OP_WIDTH       2
`define CC_OP_IDLE        2'h0
`define CC_OP_READ        2'h1
`define CC_OP_CHECK_READ  2'h2
`define CC_OP_WRITE       2'h3
`define CC_INSTR_CONTINUE 8'h46
`define CC_INSTR_CONT_GAP 8'h47
`define CC_BLOCK_CHARS    720
`define CC_STATE_WIDTH    4
`endif

// ===== core/tape_continue_pkg.sv
// Types shared by the tape continue control files.
package tape_continue_pkg;
    typedef enum logic [3:0] {
        ST_IDLE  = 4'b0001,
        ST_READ  = 4'b0010,
        ST_CHECK = 4'b0100,
        ST_WRITE = 4'b1000
    } op_state_t;
endpackage : tape_continue_pkg

// ===== core/cc_event_flag.sv
// Sticky flag with set-over-clear priority.
module cc_event_flag (
    input  wire logic sys_clk_i,
    input  wire logic rst_i,
    input  wire logic set_i,
    input  wire logic clr_i,
    output logic      flag_o
);
    // A set arriving with a clear wins, so no event is lost.
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            flag_o <= 1'b0;
        end else if (set_i) begin
            flag_o <= 1'b1;
        end else if (clr_i) begin
            flag_o <= 1'b0;
        end
    end
endmodule : cc_event_flag

// ===== core/tape_continue_control.sv
// Continue control for the tape synchronizer read, check-read and write operations.
// Behaviour
// - Continue set by 70/71, cleared at group start.
// - Only 71 sets continue-beyond-gap.
// - Native read: gap flag needs last blockette.
// - Gap flag cleared on gap insert/detect.
// - Read without continue sets check-read.
// - Group end sets continue-check, clears gap flag.
// - Gap flag clear enables read ending.
// - 70/71 with continue-check raise error.
// - Gap flag set inhibits read ending.
// - Continue blocks check-read/continue-check gate.
// - Read ends at group only before gap.
// - Read error clears both continue flags.
// - Started check-read runs to block end.
// - Check-read error clears both continue flags.
// - Write without continue: continue-check at nine words.
// - Continue-check triggers write ending.
// - No continue blocks memory request after tenth.
// - 71 in first nine words inserts gap.
// - Write error clears both continue flags.
// - 70/71 after read end or idle error.
`include "tape_continue_consts.svh"
module tape_continue_control
    import tape_continue_pkg::*;
(
    // Clock and reset.
    input  wire logic       sys_clk_i,
    input  wire logic       rst_i,
    // Program instructions, one-cycle pulses.
    input  wire logic       instr_continue_i,
    input  wire logic       instr_cont_gap_i,
    // Operation start and type.
    input  wire logic       op_start_i,
    input  wire logic [1:0] op_kind_i,
    input  wire logic       op_end_i,
    input  wire logic       native_format_i,
    // Read and write circuit events.
    input  wire logic       ten_word_set_i,
    input  wire logic       group_end_i,
    input  wire logic       gap_follows_i,
    input  wire logic       blockette_last_group_i,
    input  wire logic       write_gap_insert_begin_i,
    input  wire logic       read_gap_detect_i,
    input  wire logic       nine_words_done_i,
    input  wire logic       tenth_word_fetched_i,
    input  wire logic       block_end_i,
    input  wire logic       rw_error_i,
    // Flag state.
    output logic            continue_o,
    output logic            continue_gap_o,
    output logic            continue_check_o,
    output logic            check_read_o,
    output logic            rw_error_o,
    // Controls to the read, write and buffer circuits.
    output logic            group_end_no_continue_o,
    output logic            read_end_enable_o,
    output logic            read_stop_o,
    output logic            write_end_o,
    output logic            write_gap_request_o,
    output logic            mem_request_block_o,
    output logic            continue_check_error_o
);
    op_state_t  state_q;
    op_state_t  state_d;
    logic       continue_q;
    logic       gap_q;
    logic       check_read_q;
    logic       read_ended_q;
    logic       any_instr;
    logic       in_op;
    logic       gap_allowed;
    logic       zen;
    logic       cc_set;
    logic       cc_clr;
    logic       cc_flag;
    logic       err_q;

    function automatic logic is_kind(input logic [1:0] k, input logic [1:0] ref_k);
        is_kind = (k == ref_k);
    endfunction : is_kind

    assign any_instr = instr_continue_i | instr_cont_gap_i;
    assign in_op     = (state_q != ST_IDLE);

    always_comb begin
        state_d = state_q;
        case (state_q)
            ST_IDLE: begin
                if (op_start_i && is_kind(op_kind_i, `CC_OP_READ)) begin
                    state_d = ST_READ;
                end else if (op_start_i && is_kind(op_kind_i, `CC_OP_CHECK_READ)) begin
                    state_d = ST_CHECK;
                end else if (op_start_i && is_kind(op_kind_i, `CC_OP_WRITE)) begin
                    state_d = ST_WRITE;
                end
            end
            ST_READ, ST_CHECK, ST_WRITE: begin
                if (op_end_i) begin
                    state_d = ST_IDLE;
                end
            end
            default: state_d = ST_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            state_q <= ST_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // End of a read group with no continue pending.
    assign zen = (state_q == ST_READ) && !check_read_q && group_end_i && !continue_q;

    // The gap flag may only be taken on native read when the blockette counter allows.
    assign gap_allowed = (state_q == ST_WRITE) ||
                         !native_format_i || blockette_last_group_i;

    // Continue flag: instruction sets win over the group-start clear.
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            continue_q <= 1'b0;
        end else if (op_start_i) begin
            continue_q <= 1'b0;
        end else if (rw_error_i) begin
            continue_q <= 1'b0;
        end else if (any_instr && in_op && !cc_flag && !read_ended_q) begin
            continue_q <= 1'b1;
        end else if (ten_word_set_i) begin
            continue_q <= 1'b0;
        end
    end

    // Continue-beyond-gap flag.
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            gap_q <= 1'b0;
        end else if (op_start_i) begin
            gap_q <= 1'b0;
        end else if (rw_error_i || zen || cc_set) begin
            gap_q <= 1'b0;
        end else if (instr_cont_gap_i && in_op && !cc_flag && !read_ended_q && gap_allowed) begin
            gap_q <= 1'b1;
        end else if ((state_q == ST_WRITE) && write_gap_insert_begin_i) begin
            gap_q <= 1'b0;
        end else if ((state_q != ST_WRITE) && read_gap_detect_i) begin
            gap_q <= 1'b0;
        end
    end

    // Check-read once begun holds until the block ends, regardless of instructions.
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            check_read_q <= 1'b0;
        end else if (op_start_i) begin
            check_read_q <= is_kind(op_kind_i, `CC_OP_CHECK_READ);
        end else if (zen) begin
            check_read_q <= 1'b1;
        end else if (block_end_i && !gap_q) begin
            check_read_q <= 1'b0;
        end
    end

    // Read-to-memory has ended once check-read took over.
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            read_ended_q <= 1'b0;
        end else if (op_start_i) begin
            read_ended_q <= 1'b0;
        end else if (zen) begin
            read_ended_q <= 1'b1;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            err_q <= 1'b0;
        end else if (rw_error_i) begin
            err_q <= 1'b1;
        end else if (op_start_i) begin
            err_q <= 1'b0;
        end
    end

    assign cc_set = zen || ((state_q == ST_WRITE) && nine_words_done_i && !continue_q
                    && !any_instr);
    assign cc_clr = op_start_i;

    cc_event_flag u_cc_flag (
        .sys_clk_i (sys_clk_i),
        .rst_i     (rst_i),
        .set_i     (cc_set),
        .clr_i     (cc_clr),
        .flag_o    (cc_flag)
    );

    // Error pulse is registered so the program sees it one cycle after the instruction.
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            continue_check_error_o <= 1'b0;
        end else begin
            continue_check_error_o <= any_instr && (cc_flag || !in_op || read_ended_q);
        end
    end

    assign continue_o       = continue_q;
    assign continue_gap_o   = gap_q;
    assign continue_check_o = cc_flag;
    assign check_read_o     = check_read_q;
    assign rw_error_o       = err_q;
    assign group_end_no_continue_o = zen;
    // Read ending is only armed when the gap flag is clear.
    assign read_end_enable_o = (state_q == ST_READ || state_q == ST_CHECK) && !gap_q;
    // Reading stops at a group boundary only when a gap follows it.
    assign read_stop_o = read_end_enable_o && check_read_q && group_end_i && gap_follows_i;
    assign write_end_o = (state_q == ST_WRITE) && cc_flag;
    assign write_gap_request_o = (state_q == ST_WRITE) && gap_q;
    assign mem_request_block_o = (state_q == ST_WRITE) && !continue_q &&
                                 tenth_word_fetched_i;
endmodule : tape_continue_control

// ===== tb/cc_program_model.sv
// Program model that issues continue instructions as one-cycle pulses.
`include "tape_continue_consts.svh"
module cc_program_model (
    input  wire logic sys_clk_i,
    output logic      instr_continue_o,
    output logic      instr_cont_gap_o
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        instr_continue_o = 1'b0;
        instr_cont_gap_o = 1'b0;
    end
    // The bench picks the moment of each call, inside the group it wants to extend.
    task automatic issue(input logic [7:0] code);
        @(posedge sys_clk_i);
        #1 instr_continue_o = (code === `CC_INSTR_CONTINUE);
        instr_cont_gap_o = (code === `CC_INSTR_CONT_GAP);
        @(posedge sys_clk_i);
        #1 instr_continue_o = 1'b0;
        instr_cont_gap_o = 1'b0;
    endtask : issue
endmodule : cc_program_model

// ===== tb/tape_continue_control_monitor.sv
// Checker for the continue, gap and continue-check flags.
module tape_continue_control_monitor (
    input wire logic sys_clk_i, rst_i, instr_continue_i, instr_cont_gap_i, op_start_i,
    input wire logic ten_word_set_i, read_gap_detect_i, write_gap_insert_begin_i, rw_error_i,
    input wire logic continue_o, continue_gap_o, continue_check_o, check_read_o,
    input wire logic group_end_no_continue_o, read_end_enable_o, continue_check_error_o
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (rst_i);
    wire logic ins = instr_continue_i | instr_cont_gap_i;
    a_cont_rise_cause: assert property ($rose(continue_o) |-> $past(ins))
        else $error("continue rose without instruction");
    a_cont_group_clear: assert property (ten_word_set_i && !ins |=> !continue_o)
        else $error("continue kept at group start");
    a_gap_only_71: assert property ($rose(continue_gap_o) |-> $past(instr_cont_gap_i))
        else $error("gap flag set without 71");
    a_gap_event_clear: assert property ((read_gap_detect_i || write_gap_insert_begin_i)
        && !instr_cont_gap_i |=> !continue_gap_o)
        else $error("gap flag kept at gap");
    a_zen_sets_check: assert property (group_end_no_continue_o && !op_start_i
        |=> check_read_o && continue_check_o && !continue_gap_o)
        else $error("group end did not set check flags");
    a_zen_needs_clear: assert property (group_end_no_continue_o |-> !continue_o)
        else $error("group end gate open with continue set");
    a_gap_inhibit_end: assert property (continue_gap_o |-> !read_end_enable_o)
        else $error("read ending enabled with gap flag");
    a_error_clears: assert property (rw_error_i && !op_start_i
        |=> !continue_o && !continue_gap_o)
        else $error("error left continue flags");
    a_start_clears: assert property (op_start_i
        |=> !continue_o && !continue_gap_o && !continue_check_o)
        else $error("start left flags");
    a_check_error: assert property (continue_check_o && ins && !op_start_i
        |=> continue_check_error_o)
        else $error("no continue-check error");
    c_zen: cover property (group_end_no_continue_o);
    c_gap_set: cover property ($rose(continue_gap_o));
    c_cc_error: cover property (continue_check_error_o);
endmodule : tape_continue_control_monitor
bind tape_continue_control tape_continue_control_monitor u_mon (.*);

// ===== tb/tape_continue_control_tb.sv
// Directed bench for the tape continue control block.
`include "tape_continue_consts.svh"
module tape_continue_control_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic       sys_clk_i = 1'b0;
    logic       rst_i = 1'b1;
    logic [8:0] ev = 9'h000;
    logic [1:0] kind = 2'h0;
    logic       nat = 1'b0;
    logic       lastg = 1'b0;
    logic       gf = 1'b0;
    logic       tenth = 1'b0;
    logic       i70, i71, cont, cgap, cchk, crd, ree, wend, cerr;
    logic       rwe, rstop, wgap, mrb;
    int         err_total = 0;
    int         n_compared = 0;
    initial forever #25 sys_clk_i = ~sys_clk_i;
    cc_program_model u_prog (.sys_clk_i(sys_clk_i), .instr_continue_o(i70),
        .instr_cont_gap_o(i71));
    tape_continue_control u_dut (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
        .instr_continue_i(i70), .instr_cont_gap_i(i71), .op_start_i(ev[0]),
        .op_kind_i(kind), .op_end_i(ev[1]), .native_format_i(nat),
        .ten_word_set_i(ev[2]), .group_end_i(ev[3]), .gap_follows_i(gf),
        .blockette_last_group_i(lastg), .write_gap_insert_begin_i(ev[4]),
        .read_gap_detect_i(ev[5]), .nine_words_done_i(ev[6]),
        .tenth_word_fetched_i(tenth), .block_end_i(ev[7]), .rw_error_i(ev[8]),
        .continue_o(cont), .continue_gap_o(cgap), .continue_check_o(cchk),
        .check_read_o(crd), .rw_error_o(rwe), .group_end_no_continue_o(),
        .read_end_enable_o(ree), .read_stop_o(rstop), .write_end_o(wend),
        .write_gap_request_o(wgap), .mem_request_block_o(mrb),
        .continue_check_error_o(cerr));
    task automatic chk(input string name, input logic seen, input logic exp);
        n_compared++;
        if (seen !== exp) begin
            err_total++;
            $display("wrong value %s expected %b seen %b", name, exp, seen);
        end
    endtask : chk
    task automatic pulse(input int b);
        @(posedge sys_clk_i);
        #1 ev[b] = 1'b1;
        @(posedge sys_clk_i);
        #1 ev = 9'h000;
    endtask : pulse
    task automatic tally_and_finish();
        $display("compared %0d mismatched %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : tally_and_finish
    initial begin
        #100000 err_total++;
        tally_and_finish();
    end
    initial begin
        repeat (10) @(posedge sys_clk_i);
        #1 rst_i = 1'b0;
        chk("continue", cont, 1'b0);
        u_prog.issue(`CC_INSTR_CONTINUE);
        chk("error idle", cerr, 1'b1);
        kind = `CC_OP_READ;
        nat = 1'b1;
        lastg = 1'b1;
        pulse(0);
        u_prog.issue(`CC_INSTR_CONT_GAP);
        chk("continue", cont, 1'b1);
        chk("gap", cgap, 1'b1);
        chk("end enable", ree, 1'b0);
        pulse(2);
        chk("continue", cont, 1'b0);
        pulse(5);
        chk("gap", cgap, 1'b0);
        lastg = 1'b0;
        u_prog.issue(`CC_INSTR_CONT_GAP);
        chk("gap", cgap, 1'b0);
        pulse(8);
        chk("continue", cont, 1'b0);
        chk("rw error", rwe, 1'b1);
        pulse(3);
        chk("check read", crd, 1'b1);
        chk("cont check", cchk, 1'b1);
        u_prog.issue(`CC_INSTR_CONTINUE);
        chk("error", cerr, 1'b1);
        chk("end enable", ree, 1'b1);
        // Hold the group end while the gap-follows level is toggled.
        @(posedge sys_clk_i);
        #1 gf = 1'b1;
        ev[3] = 1'b1;
        #1 chk("read stop", rstop, 1'b1);
        @(posedge sys_clk_i);
        #1 gf = 1'b0;
        #1 chk("read stop", rstop, 1'b0);
        @(posedge sys_clk_i);
        #1 ev = 9'h000;
        // The current read must end before a new operation is accepted.
        pulse(1);
        kind = `CC_OP_WRITE;
        pulse(0);
        chk("cont check", cchk, 1'b0);
        tenth = 1'b1;
        u_prog.issue(`CC_INSTR_CONT_GAP);
        chk("gap", cgap, 1'b1);
        chk("write gap", wgap, 1'b1);
        chk("mem block", mrb, 1'b0);
        pulse(4);
        chk("gap", cgap, 1'b0);
        pulse(2);
        chk("mem block", mrb, 1'b1);
        pulse(6);
        chk("cont check", cchk, 1'b1);
        chk("write end", wend, 1'b1);
        pulse(1);
        kind = `CC_OP_CHECK_READ;
        pulse(0);
        chk("check read", crd, 1'b1);
        u_prog.issue(`CC_INSTR_CONTINUE);
        chk("continue", cont, 1'b1);
        chk("check read", crd, 1'b1);
        pulse(8);
        chk("continue", cont, 1'b0);
        pulse(7);
        chk("check read", crd, 1'b0);
        tally_and_finish();
    end
endmodule : tape_continue_control_tb
